// ==== rsa_pkg.sv ====
// Constants and state codes for the clock chip's two-wire slave access block
`default_nettype none

package rsa_pkg;

  // Fixed seven-bit bus address of the device
  localparam logic [6:0] SLAVE_ADDR    = 7'h32;
  // Pointer value after reset, stop or abort
  localparam logic [3:0] PTR_DEFAULT   = 4'hf;
  // Format code that starts read data right after the pointer byte
  localparam logic [3:0] FMT_DIRECT_RD = 4'h4;
  // Format code for plain writes and for the repeated-start read
  localparam logic [3:0] FMT_PLAIN     = 4'h0;
  // Bits in one byte before the acknowledge slot
  localparam logic [3:0] BYTE_BITS     = 4'h8;

  // Field positions inside the address byte and the pointer byte
  localparam int DIR_BIT = 0;
  localparam int PTR_HI  = 7;
  localparam int PTR_LO  = 4;
  localparam int FMT_HI  = 3;
  localparam int FMT_LO  = 0;

  // Core clock rate and the access watchdog time
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int TIMEOUT_MS   = 500;
  // Least time rounds up; this one divides exactly
  localparam int TIMEOUT_CYC  = TIMEOUT_MS * CLK_FREQ_KHZ;
  localparam int TMO_W        = 32;

  // Byte-level states of the slave sequencer
  typedef enum logic [2:0] {
    RSA_IDLE   = 3'b000,
    RSA_ADDR   = 3'b001,
    RSA_PTR    = 3'b010,
    RSA_WDATA  = 3'b011,
    RSA_RDATA  = 3'b100,
    RSA_IGNORE = 3'b101
  } rsa_state_t;

endpackage

`default_nettype wire

// ==== rsa_bus_cond.sv ====
// Line synchroniser and start, stop and clock-edge detector for the two-wire bus
`timescale 1ns/100ps
`default_nettype none

module rsa_bus_cond (
  input  wire logic core_clk_in,   // Core clock
  input  wire logic rst_b_in,      // Asynchronous reset, active low
  input  wire logic scl_in,        // Raw bus clock pin
  input  wire logic sda_in,        // Raw bus data pin
  output logic      sda_out,       // Synchronised data level
  output logic      scl_rise_out,  // Bus clock rose
  output logic      scl_fall_out,  // Bus clock fell
  output logic      start_out,     // Start or repeated start seen
  output logic      stop_out       // Stop seen
);

  logic scl_meta_reg;  // First stage, read by the second only
  logic sda_meta_reg;  // First stage, read by the second only
  logic scl_sync_reg;  // Second stage
  logic sda_sync_reg;  // Second stage
  logic scl_prev_reg;  // Previous synced clock
  logic sda_prev_reg;  // Previous synced data

  // Two flip-flops per pin; lines idle high so reset to one
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_meta_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_in;
      sda_meta_reg <= sda_in;
      scl_sync_reg <= scl_meta_reg;
      sda_sync_reg <= sda_meta_reg;
    end
  end

  // History stage for edge detection
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_sync_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  // Data edges while the clock stays high mark start and stop
  assign start_out    = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  assign stop_out     = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;
  assign scl_rise_out = scl_sync_reg & ~scl_prev_reg;
  assign scl_fall_out = ~scl_sync_reg & scl_prev_reg;
  assign sda_out      = sda_sync_reg;

endmodule

`default_nettype wire

// ==== rsa_slave.sv ====
// Two-wire slave access block of the clock chip: addressing, pointer, carry hold, watchdog
`timescale 1ns/100ps
`default_nettype none

module rsa_slave #(
  parameter int unsigned TIMEOUT_CYC = rsa_pkg::TIMEOUT_CYC  // Watchdog length in cycles
) (
  input  wire logic       core_clk_in,      // Core clock, 100 MHz
  input  wire logic       rst_b_in,         // Asynchronous reset, active low
  input  wire logic       scl_in,           // Bus clock pin
  input  wire logic       sda_in,           // Bus data pin level
  output logic            sda_out,          // Bus data drive level, always low
  output logic            sda_oe_b_out,     // Data pin enable, low pulls line low
  output logic [3:0]      reg_addr_out,     // Internal register address
  output logic [7:0]      reg_wdata_out,    // Write data
  output logic            reg_wr_out,       // Write strobe
  output logic            reg_rd_out,       // Read strobe
  input  wire logic [7:0] reg_rdata_in,     // Read data for reg_addr_out
  input  wire logic       carry_in,         // Carry pulse from time counters
  output logic            carry_hold_out,   // Carries are frozen
  output logic            carry_apply_out   // Apply one carry now
);

  // Synchronised bus events
  logic       sda_s;        // Synced data level
  logic       scl_rise;     // Clock rising edge
  logic       scl_fall;     // Clock falling edge
  logic       start_p;      // Start condition
  logic       stop_p;       // Stop condition

  // Sequencer state
  rsa_pkg::rsa_state_t st_reg;   // Byte-level state
  logic [3:0] cnt_reg;      // Bits seen in this byte
  logic       ack_reg;      // In the ninth clock slot
  logic [7:0] shift_reg;    // Receive shifter
  logic [7:0] tx_reg;       // Transmit shifter
  logic       drv_reg;      // Wants to pull data low
  logic       rd_dir_reg;   // Direction bit of last address
  logic [3:0] ptr_reg;      // Internal address pointer
  logic [3:0] fmt_reg;      // Transfer format code
  logic [7:0] wdata_reg;    // Write data holding
  logic       wr_reg;       // Write strobe flop
  logic       rd_reg;       // Read strobe flop

  // Access session and watchdog
  // Session stays busy through an abort, so later starts cannot re-arm it
  logic             busy_reg;   // Between first start and stop
  logic             abort_reg;  // Watchdog fired in this access
  logic [31:0]      tmo_reg;    // Cycles since first start
  logic             tmo_hit;    // Watchdog expiry this cycle

  // Carry hold
  logic       pend_reg;     // Carry waiting for release
  logic       apply_reg;    // Carry apply pulse
  logic       hold;         // Carries frozen

  // Pointer advance; four bits, so Fh rolls over to 0h by itself
  function automatic logic [3:0] ptr_step(input logic [3:0] ptr);
    return ptr + 4'h1;
  endfunction

  // Open-drain level for a data bit: pull low for a zero, release for a one
  function automatic logic pull_for(input logic data_bit);
    return ~data_bit;
  endfunction

  // Edge and condition detector with pin synchronisers
  // Every pin edge lands on the core clock, at two cycles of latency
  rsa_bus_cond u_cond (
    .core_clk_in  (core_clk_in),
    .rst_b_in     (rst_b_in),
    .scl_in       (scl_in),
    .sda_in       (sda_in),
    .sda_out      (sda_s),
    .scl_rise_out (scl_rise),
    .scl_fall_out (scl_fall),
    .start_out    (start_p),
    .stop_out     (stop_p)
  );

  // Watchdog counts from the first start only
  // Trade-off: one fixed count at the short end of the window keeps it
  // simple; a master inside its 0.5 s budget never meets it
  assign tmo_hit = busy_reg & ~abort_reg
                 & (tmo_reg == 32'(TIMEOUT_CYC - 32'd1));

  // Access session: first start opens, stop closes, watchdog aborts
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_reg  <= 1'b0;
      abort_reg <= 1'b0;
      tmo_reg   <= 32'h0;
    end else if (stop_p) begin
      // Stop ends the access and clears the abort
      busy_reg  <= 1'b0;
      abort_reg <= 1'b0;
      tmo_reg   <= 32'h0;
    end else if (start_p && !busy_reg) begin
      // Only the first start arms the watchdog
      busy_reg  <= 1'b1;
      tmo_reg   <= 32'h0;
    end else if (tmo_hit) begin
      // Abort stays until the master finally sends stop
      abort_reg <= 1'b1;
    end else if (busy_reg && !abort_reg) begin
      tmo_reg   <= tmo_reg + 32'h1;
    end
  end

  // Carries freeze during a live access
  assign hold = busy_reg & ~abort_reg;

  // Held carry kept pending; a new carry wins over the release
  // Several carries inside one access collapse into one apply
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pend_reg  <= 1'b0;
      apply_reg <= 1'b0;
    end else begin
      // Applied one cycle after release, far inside the 61 us budget
      apply_reg <= ~hold & (carry_in | pend_reg);
      if (carry_in && hold) begin
        pend_reg <= 1'b1;
      end else if (!hold) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // Byte sequencer: shifting, acknowledge slots, pointer and strobes
  // Stop and watchdog outrank start, so a cut frame always parks the
  // pointer even when the master vanished in the middle of a byte
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg     <= rsa_pkg::RSA_IDLE;
      cnt_reg    <= 4'h0;
      ack_reg    <= 1'b0;
      shift_reg  <= 8'h00;
      tx_reg     <= 8'hff;
      drv_reg    <= 1'b0;
      rd_dir_reg <= 1'b0;
      ptr_reg    <= rsa_pkg::PTR_DEFAULT;
      fmt_reg    <= rsa_pkg::FMT_PLAIN;
      wdata_reg  <= 8'h00;
      wr_reg     <= 1'b0;
      rd_reg     <= 1'b0;
    end else begin
      // Strobes last one cycle
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      if (stop_p || tmo_hit) begin
        // Stop and abort both park the pointer at Fh
        st_reg  <= rsa_pkg::RSA_IDLE;
        ptr_reg <= rsa_pkg::PTR_DEFAULT;
        drv_reg <= 1'b0;
        ack_reg <= 1'b0;
      end else if (start_p) begin
        // Any start, first or repeated, expects an address next
        st_reg  <= rsa_pkg::RSA_ADDR;
        cnt_reg <= 4'h0;
        ack_reg <= 1'b0;
        drv_reg <= 1'b0;
      end else begin
        unique case (st_reg)
          rsa_pkg::RSA_IDLE, rsa_pkg::RSA_IGNORE: begin
            // Shifter left alone: nothing here is meant for us
            // Line left released until the next start
            drv_reg <= 1'b0;
          end
          rsa_pkg::RSA_ADDR, rsa_pkg::RSA_PTR, rsa_pkg::RSA_WDATA: begin
            if (scl_rise && !ack_reg) begin
              // Bits arrive MSB first
              shift_reg <= {shift_reg[6:0], sda_s};
              cnt_reg   <= cnt_reg + 4'h1;
            end else if (scl_fall && !ack_reg && cnt_reg == rsa_pkg::BYTE_BITS) begin
              ack_reg <= 1'b1;
              if (st_reg == rsa_pkg::RSA_ADDR
                  && shift_reg[7:1] != rsa_pkg::SLAVE_ADDR) begin
                // Someone else's address: go silent
                st_reg <= rsa_pkg::RSA_IGNORE;
              end else begin
                // Pull low for the ninth clock
                drv_reg <= 1'b1;
                if (st_reg == rsa_pkg::RSA_ADDR) begin
                  rd_dir_reg <= shift_reg[rsa_pkg::DIR_BIT];
                end
                if (st_reg == rsa_pkg::RSA_PTR) begin
                  // Pointer in the high nibble, format in the low
                  ptr_reg <= shift_reg[rsa_pkg::PTR_HI:rsa_pkg::PTR_LO];
                  fmt_reg <= shift_reg[rsa_pkg::FMT_HI:rsa_pkg::FMT_LO];
                end
                if (st_reg == rsa_pkg::RSA_WDATA) begin
                  // Pointer still names this byte's register while wr stands
                  // Store at the pointer; suppressed while aborted
                  wdata_reg <= shift_reg;
                  wr_reg    <= ~abort_reg;
                end
              end
            end else if (scl_fall && ack_reg) begin
              // End of the acknowledge slot
              ack_reg <= 1'b0;
              cnt_reg <= 4'h0;
              drv_reg <= 1'b0;
              if (st_reg == rsa_pkg::RSA_ADDR && rd_dir_reg) begin
                // Read from the current pointer: Fh when fresh
                st_reg  <= rsa_pkg::RSA_RDATA;
                tx_reg  <= reg_rdata_in;
                drv_reg <= pull_for(reg_rdata_in[7]);
                rd_reg  <= 1'b1;
              end else if (st_reg == rsa_pkg::RSA_ADDR) begin
                // A write address byte is followed by the pointer byte
                st_reg <= rsa_pkg::RSA_PTR;
              end else if (st_reg == rsa_pkg::RSA_PTR
                           && fmt_reg == rsa_pkg::FMT_DIRECT_RD) begin
                // Short read: data follows without a direction change
                st_reg  <= rsa_pkg::RSA_RDATA;
                tx_reg  <= reg_rdata_in;
                drv_reg <= pull_for(reg_rdata_in[7]);
                rd_reg  <= 1'b1;
              end else if (st_reg == rsa_pkg::RSA_PTR) begin
                // Any other code is taken as the plain write format
                st_reg <= rsa_pkg::RSA_WDATA;
              end else begin
                // Next data byte goes one up, Fh wraps to 0h
                ptr_reg <= ptr_step(ptr_reg);
              end
            end
          end
          rsa_pkg::RSA_RDATA: begin
            if (scl_rise && !ack_reg) begin
              // The master samples this bit at the end of the high phase
              cnt_reg <= cnt_reg + 4'h1;
            end else if (scl_fall && !ack_reg) begin
              if (cnt_reg == rsa_pkg::BYTE_BITS) begin
                // Release for the master's acknowledge
                ack_reg <= 1'b1;
                drv_reg <= 1'b0;
              end else begin
                // Next bit; ones release the line
                drv_reg <= pull_for(tx_reg[6]);
                tx_reg  <= {tx_reg[6:0], 1'b1};
              end
            end else if (scl_rise && ack_reg) begin
              // Pointer moves on after each byte sent
              ptr_reg <= ptr_step(ptr_reg);
              if (sda_s) begin
                // No acknowledge: master is done reading
                st_reg <= rsa_pkg::RSA_IGNORE;
              end
            end else if (scl_fall && ack_reg) begin
              // Load the next byte from the advanced pointer
              ack_reg <= 1'b0;
              cnt_reg <= 4'h0;
              tx_reg  <= reg_rdata_in;
              drv_reg <= pull_for(reg_rdata_in[7]);
              rd_reg  <= 1'b1;
            end
          end
          default: begin
            // Illegal code recovers to idle
            st_reg <= rsa_pkg::RSA_IDLE;
          end
        endcase
      end
    end
  end

  // Read data is taken combinationally at the load edge: the clock core
  // must show the register at reg_addr_out within the same cycle
  // Open drain: after an abort nothing is driven, so reads see FFh
  assign sda_out         = 1'b0;
  assign sda_oe_b_out    = ~(drv_reg & ~abort_reg);
  assign reg_addr_out    = ptr_reg;
  assign reg_wdata_out   = wdata_reg;
  assign reg_wr_out      = wr_reg;
  assign reg_rd_out      = rd_reg;
  assign carry_hold_out  = hold;
  assign carry_apply_out = apply_reg;

endmodule

`default_nettype wire

// ==== rsa_slave_checker.sv ====
// Port-level checks for the two-wire slave access block
`timescale 1ns/100ps
`default_nettype none

module rsa_slave_checker #(
  parameter int unsigned TIMEOUT_CYC = 2000  // Watchdog length in cycles
) (
  input wire logic       core_clk_in,
  input wire logic       rst_b_in,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_b_out,
  input wire logic [3:0] reg_addr_out,
  input wire logic [7:0] reg_wdata_out,
  input wire logic       reg_wr_out,
  input wire logic       reg_rd_out,
  input wire logic [7:0] reg_rdata_in,
  input wire logic       carry_in,
  input wire logic       carry_hold_out,
  input wire logic       carry_apply_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);

  logic [31:0] hold_cnt_reg;  // Cycles spent inside one access

  // Length of the current access, so the watchdog bound can be checked
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hold_cnt_reg <= 32'h0;
    end else begin
      hold_cnt_reg <= carry_hold_out ? hold_cnt_reg + 32'h1 : 32'h0;
    end
  end

  a_wr_pulse: assert property (reg_wr_out |=> !reg_wr_out)
    else $error("write strobe lasted more than one cycle");
  a_wr_access: assert property (reg_wr_out |-> carry_hold_out)
    else $error("write strobe outside a live access");
  a_apply_free: assert property (carry_in && !carry_hold_out |=> carry_apply_out)
    else $error("free carry not applied next cycle");
  a_apply_held: assert property (carry_apply_out |-> !$past(carry_hold_out))
    else $error("carry applied while carries were frozen");
  a_hold_start: assert property ($rose(carry_hold_out) |-> scl_in && !sda_in)
    else $error("carry hold began without a start");
  a_stop_ptr: assert property ($fell(carry_hold_out)
      |-> ##[0:2] reg_addr_out == 4'hf)
    else $error("pointer not Fh after end of access");
  a_drive_scl_low: assert property ($changed(sda_oe_b_out) |-> !scl_in)
    else $error("data drive changed while bus clock high");
  a_idle_release: assert property (!carry_hold_out [*2] |-> sda_oe_b_out)
    else $error("data line driven outside an access");
  a_hold_bound: assert property (hold_cnt_reg <= TIMEOUT_CYC + 4)
    else $error("access outlived the watchdog");
  a_rd_pulse: assert property (reg_rd_out |=> !reg_rd_out)
    else $error("read strobe lasted more than one cycle");
  a_rd_scl_low: assert property (reg_rd_out |-> !scl_in)
    else $error("read byte loaded while bus clock high");
  a_od_low: assert property (!sda_oe_b_out |-> !sda_out)
    else $error("data pin enabled with a high drive level");
endmodule

`default_nettype wire

// ==== rsa_bus_master.sv ====
// Behavioural two-wire bus master that drives the slave's pins
`timescale 1ns/100ps
`default_nettype none

module rsa_bus_master (
  input  wire logic core_clk_in,  // Core clock, used for pacing only
  input  wire logic sda_line_in,  // Resolved data line
  output logic      scl_out,      // Bus clock, idle high
  output logic      sda_drv_out   // Data drive, 1 releases to pull-up
);
  // Bus idles high on both lines
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
  end

  // Wait a number of core cycles, changing nothing
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask

  // One bus phase; eight cycles keeps well above the four-cycle minimum
  task automatic half();
    idle(8);
  endtask

  // Start or repeated start
  task automatic start_c();
    sda_drv_out = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    sda_drv_out = 1'b0;  // Data falls, clock high
    half();
    scl_out = 1'b0;
    half();
  endtask

  // Stop, then the quiet gap so a held carry lands first
  task automatic stop_c();
    sda_drv_out = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    sda_drv_out = 1'b1;  // Data rises, clock high
    idle(6200);  // 62 us before any new start
  endtask

  // One bit: data set while clock low, sampled at end of high phase
  task automatic bit_x(input logic tx, output logic rx);
    sda_drv_out = tx;
    half();
    scl_out = 1'b1;
    half();
    rx = sda_line_in;
    scl_out = 1'b0;
    half();
  endtask

  // Eight data bits then the acknowledge slot
  task automatic byte_x(input logic [7:0] tx, input logic ack_tx, output logic [7:0] rx,
                        output logic ack_rx);
    for (int i = 7; i >= 0; i--) begin  // Most significant bit first
      bit_x(tx[i], rx[i]);
    end
    bit_x(ack_tx, ack_rx);  // Ninth clock acknowledge
  endtask
endmodule

`default_nettype wire

// ==== rsa_slave_bench.sv ====
// Self-checking bench for the two-wire slave access block
`timescale 1ns/100ps
`default_nettype none

module rsa_slave_bench;
  localparam int unsigned TMO = 2000;  // Shortened watchdog
  localparam logic ACK = 1'b0;         // Line pulled low
  localparam logic NAK = 1'b1;         // Line left high

  logic       core_clk_in, rst_b_in, scl_in, sda_drv, sda_out, sda_oe_b_out;
  logic [3:0] reg_addr_out;
  logic [7:0] reg_wdata_out, reg_rdata_in, rx;
  logic       reg_wr_out, reg_rd_out, carry_in, carry_hold_out, carry_apply_out, ak;
  wire logic  sda_in;
  logic [7:0] regs [16];  // Clock core registers
  int miscompares = 0;
  int num_checks = 0;
  int applies = 0;

  // Open-drain line with pull-up
  assign sda_in = sda_drv & (sda_oe_b_out | sda_out);
  assign reg_rdata_in = regs[reg_addr_out];

  rsa_slave #(.TIMEOUT_CYC(TMO)) dut (.core_clk_in, .rst_b_in, .scl_in, .sda_in, .sda_out,
    .sda_oe_b_out, .reg_addr_out, .reg_wdata_out, .reg_wr_out, .reg_rd_out, .reg_rdata_in,
    .carry_in, .carry_hold_out, .carry_apply_out);
  rsa_bus_master master (.core_clk_in, .sda_line_in(sda_in), .scl_out(scl_in),
    .sda_drv_out(sda_drv));

  // Register file and carry counter of the clock core
  always @(posedge core_clk_in) begin
    if (reg_wr_out) regs[reg_addr_out] <= reg_wdata_out;
    if (carry_apply_out) applies <= applies + 1;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic send(input logic [7:0] b, input logic ack_exp);
    master.byte_x(b, NAK, rx, ak);
    check("acknowledge", {7'h0, ak}, {7'h0, ack_exp});
  endtask

  task automatic fetch(input logic [7:0] exp, input logic ack_tx);
    master.byte_x(8'hff, ack_tx, rx, ak);
    check("read data", rx, exp);
  endtask

  task automatic pulse_carry();
    carry_in = 1'b1;
    @(negedge core_clk_in);
    carry_in = 1'b0;
    repeat (3) @(negedge core_clk_in);
  endtask

  task automatic t_write();
    master.start_c();
    send(8'h64, ACK);
    send(8'he0, ACK);  // Pointer Eh, format 0000
    send(8'h5a, ACK);
    send(8'hc3, ACK);
    send(8'h96, ACK);
    master.stop_c();
    check("reg e", regs[14], 8'h5a);
    check("reg f", regs[15], 8'hc3);
    check("reg 0", regs[0], 8'h96);
    check("pointer", {4'h0, reg_addr_out}, 8'h0f);
  endtask

  task automatic t_read_rs();
    master.start_c();
    send(8'h64, ACK);
    send(8'he0, ACK);
    master.start_c();  // Direction turned without a stop
    send(8'h65, ACK);
    fetch(8'h5a, ACK);
    fetch(8'hc3, ACK);
    fetch(8'h96, NAK);
    master.stop_c();
  endtask

  task automatic t_direct();
    master.start_c();
    send(8'h64, ACK);
    send(8'hf4, ACK);
    fetch(8'hc3, ACK);
    fetch(8'h96, NAK);
    master.stop_c();
  endtask

  task automatic t_plain();
    master.start_c();
    send(8'h65, ACK);
    fetch(8'hc3, ACK);
    fetch(8'h96, NAK);
    master.stop_c();
  endtask

  task automatic t_foreign();
    master.start_c();
    send(8'h66, NAK);
    fetch(8'hff, NAK);
    master.stop_c();
  endtask

  task automatic t_carry();
    int n0;
    n0 = applies;
    pulse_carry();
    check("free carry", 8'(applies - n0), 8'h01);
    master.start_c();
    pulse_carry();
    pulse_carry();
    send(8'h65, ACK);
    fetch(8'hc3, NAK);  // One byte from Fh read inside the held access
    check("held carry", 8'(applies - n0), 8'h01);
    master.stop_c();
    check("released carry", 8'(applies - n0), 8'h02);
  endtask

  task automatic t_abort();
    master.start_c();
    send(8'h64, ACK);
    send(8'h30, ACK);
    master.idle(800);
    master.start_c();
    master.idle(1000);  // Past watchdog from first start only
    check("hold", {7'h0, carry_hold_out}, 8'h00);
    check("pointer", {4'h0, reg_addr_out}, 8'h0f);
    send(8'h64, NAK);
    master.start_c();
    send(8'h65, NAK);
    fetch(8'hff, NAK);
    master.stop_c();
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  // Main sequence; every access stays under the watchdog but one
  initial begin
    rst_b_in = 1'b0;
    carry_in = 1'b0;
    for (int i = 0; i < 16; i++) begin
      regs[i] = 8'(8'ha0 + i);
    end
    repeat (16) @(negedge core_clk_in);
    rst_b_in = 1'b1;
    master.idle(4);
    t_write();
    t_read_rs();
    t_direct();
    t_plain();
    t_foreign();
    t_carry();
    t_abort();
    stop_test();
  end

  // Hang guard
  initial begin
    repeat (90000) @(posedge core_clk_in);
    miscompares++;
    stop_test();
  end
endmodule

bind rsa_slave rsa_slave_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (.core_clk_in, .rst_b_in,
  .scl_in, .sda_in, .sda_out, .sda_oe_b_out, .reg_addr_out, .reg_wdata_out, .reg_wr_out,
  .reg_rd_out, .reg_rdata_in, .carry_in, .carry_hold_out, .carry_apply_out);

`default_nettype wire
